// ==== rtl/dpp_pkg.sv ====
// Constants, field layout and carrier types of the downstream port power block.
// Assumes a 40 MHz APB clock and a hub port-status consumer of the event pulses.
// Summary of operation
// - Cable-supply enable outputs are active high: one on, zero off.
// - Enabled second-line supply without sensed voltage above 3.0 V flags a fault.
// - Same fault check on the first configuration-channel line.
// - Bleed enable output is active high: one pulls bus supply to ground.
// - Bleed enable asserts only for a brief timed interval.
// - Disabled or legacy ports keep supply and bleed enables low.
// - Enabled port pin is an input with pull-up; pull-up powers the port.
// - Enabled port pin is watched for an active-low overcurrent.
// - Disabled port pin becomes an output driven low.
// - Ports 1, 2, 4 and unsplit port 3 share one pin for both speeds.
// - Split port 3 pin governs only its high-speed part; here port 3 off also turns its superspeed part off.
// - Split port 3 superspeed part uses a separate active-high enable.
// - Without split, the separate superspeed enable stays unused and low.
package dpp_pkg;
    localparam logic [7:0] DPP_CTRL_ADDR = 8'h00;
    localparam logic [7:0] DPP_STATUS_ADDR = 8'h04;
    localparam logic [7:0] DPP_MASK_ADDR = 8'h08;
    localparam logic [7:0] DPP_SENSE_ADDR = 8'h0C;
    localparam int DPP_CTRL_PORT_EN_LSB = 0;
    localparam int DPP_CTRL_SPLIT_BIT = 4;
    localparam int DPP_CTRL_SS_PWR_BIT = 5;
    localparam int DPP_CTRL_CC_LSB = 8;
    localparam int DPP_CTRL_BLEED_LSB = 12;
    localparam int DPP_CTRL_LEGACY_LSB = 16;
    localparam int DPP_STAT_OC_LSB = 0;
    localparam int DPP_STAT_CC_LSB = 4;
    localparam int DPP_SENSE_BLEED_LSB = 8;
    localparam logic [31:0] DPP_CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] DPP_CTRL_WMASK = 32'h0003_0F3F;
    localparam logic [7:0] DPP_MASK_RESET = 8'h00;
    localparam int DPP_CLK_MHZ = 40;
    localparam int DPP_BLEED_TIME_US = 100;
    localparam int DPP_BLEED_CYCLES = DPP_BLEED_TIME_US * DPP_CLK_MHZ;
    typedef struct packed {
        logic [3:0] pull_up_en;
        logic [3:0] drive_oe;
        logic [3:0] drive_out;
    } dpp_pctl_type;
endpackage : dpp_pkg

// ==== rtl/dpp_port_power.sv ====
// Downstream port power control: power pins, cable supply, bleed, split port 3.
// Assumes an APB master on pclk and asynchronous pin inputs.
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
module dpp_port_power import dpp_pkg::*; #(
    parameter int BLEED_CYCLES = DPP_BLEED_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] host_port_off,
    input wire logic port1_power_ctl_sense,
    input wire logic port2_power_ctl_sense,
    input wire logic port3_power_ctl_sense,
    input wire logic port4_power_ctl_sense,
    output dpp_pctl_type power_ctl_pin,
    input wire logic port1_cc1_above_3v0,
    input wire logic port1_cc2_above_3v0,
    input wire logic port2_cc1_above_3v0,
    input wire logic port2_cc2_above_3v0,
    output logic port1_cc1_cable_supply_en,
    output logic port1_cc2_cable_supply_en,
    output logic port2_cc1_cable_supply_en,
    output logic port2_cc2_cable_supply_en,
    output logic port1_vbus_bleed_en,
    output logic port2_vbus_bleed_en,
    output logic port3_superspeed_split_power_en,
    output logic [3:0] hs_power_on,
    output logic [3:0] ss_power_on,
    output logic [3:0] overcurrent_event,
    output logic [3:0] supply_fault_event,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Agreement filter of the second and third sync stages
    function automatic logic [3:0] dpp_agree(
        input logic [3:0] old,
        input logic [3:0] s2,
        input logic [3:0] s3
    );
        dpp_agree = (s2 & ~(s2 ^ s3)) | (old & (s2 ^ s3));
    endfunction : dpp_agree

    logic [31:0] ctrl_q;
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic [7:0] mask_q;
    logic [31:0] prdata_q;
    logic [3:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_q;
    logic [3:0] cc_s1_q, cc_s2_q, cc_s3_q, cc_q;
    logic [3:0] oc_lvl_q;
    logic [3:0] fault_lvl_q;
    logic [1:0] bleed_q;
    logic [15:0] bleed_cnt_q [2];
    logic [15:0] bleed_cnt_d [2];

    ////////////////////////////////////////////////////////////////////////////
    // Register bus decode
    wire bus_access = psel & penable;
    wire bus_write = bus_access & pwrite;
    wire hit_ctrl = paddr == DPP_CTRL_ADDR;
    wire hit_status = paddr == DPP_STATUS_ADDR;
    wire hit_mask = paddr == DPP_MASK_ADDR;
    wire hit_sense = paddr == DPP_SENSE_ADDR;
    wire hit_any = hit_ctrl | hit_status | hit_mask | hit_sense;
    wire wr_ctrl = bus_write & hit_ctrl;
    wire wr_status = bus_write & hit_status;
    wire wr_mask = bus_write & hit_mask;
    wire [1:0] bleed_start = wr_ctrl ? pwdata[DPP_CTRL_BLEED_LSB +: 2] : 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Port state
    wire [3:0] cfg_en = ctrl_q[DPP_CTRL_PORT_EN_LSB +: 4];
    wire split = ctrl_q[DPP_CTRL_SPLIT_BIT];
    wire [1:0] legacy = ctrl_q[DPP_CTRL_LEGACY_LSB +: 2];
    wire [3:0] port_on = cfg_en & ~host_port_off;
    wire [1:0] native_on = port_on[1:0] & ~legacy;
    wire [3:0] cc_req = ctrl_q[DPP_CTRL_CC_LSB +: 4];
    wire [3:0] pin_raw = {port4_power_ctl_sense, port3_power_ctl_sense,
                          port2_power_ctl_sense, port1_power_ctl_sense};
    wire [3:0] cc_raw = {port2_cc2_above_3v0, port2_cc1_above_3v0,
                         port1_cc2_above_3v0, port1_cc1_above_3v0};
    wire [3:0] cc_gate = {{2{native_on[1]}}, {2{native_on[0]}}};
    wire [3:0] cc_en = cc_req & cc_gate;
    wire [3:0] oc_now = port_on & ~pin_q;
    wire [3:0] fault_now = cc_en & ~cc_q;
    wire [3:0] oc_rise = oc_now & ~oc_lvl_q;
    wire [3:0] fault_rise = fault_now & ~fault_lvl_q;
    wire [7:0] status_set = {fault_rise, oc_rise};
    wire [7:0] status_clr = wr_status ? pwdata[7:0] : 8'h00;
    wire ss_split = split & port_on[2] & ctrl_q[DPP_CTRL_SS_PWR_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Pin and output assignment
    // input with pull-up when on
    assign power_ctl_pin.pull_up_en = port_on;
    assign power_ctl_pin.drive_oe = ~port_on;
    assign power_ctl_pin.drive_out = 4'h0;
    assign port1_cc1_cable_supply_en = cc_en[0];
    assign port1_cc2_cable_supply_en = cc_en[1];
    assign port2_cc1_cable_supply_en = cc_en[2];
    assign port2_cc2_cable_supply_en = cc_en[3];
    assign port1_vbus_bleed_en = bleed_q[0];
    assign port2_vbus_bleed_en = bleed_q[1];
    assign port3_superspeed_split_power_en = ss_split;
    assign hs_power_on = port_on;
    // split port 3 superspeed needs its own enable and port 3 on
    assign ss_power_on = {port_on[3], split ? ss_split : port_on[2], port_on[1:0]};
    assign overcurrent_event = oc_rise;
    assign supply_fault_event = fault_rise;
    assign irq = |(status_q & mask_q);
    assign status_d = status_set | (status_q & ~status_clr);
    assign pready = 1'b1;
    assign pslverr = bus_access & ~hit_any;
    assign prdata = prdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Bleed interval timers
    // brief timed bleed
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (bleed_start[i] && native_on[i]) begin
                bleed_cnt_d[i] = 16'(BLEED_CYCLES);
            end else if (bleed_cnt_q[i] != 16'h0000 && native_on[i]) begin
                bleed_cnt_d[i] = bleed_cnt_q[i] - 16'h0001;
            end else begin
                bleed_cnt_d[i] = 16'h0000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bleed_cnt_q[0] <= 16'h0000;
            bleed_cnt_q[1] <= 16'h0000;
            bleed_q <= 2'h0;
        end else begin
            bleed_cnt_q[0] <= bleed_cnt_d[0];
            bleed_cnt_q[1] <= bleed_cnt_d[1];
            bleed_q <= {bleed_cnt_d[1] != 16'h0000, bleed_cnt_d[0] != 16'h0000};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    // three-stage sync with agreement
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_q <= 4'hF;
            pin_s2_q <= 4'hF;
            pin_s3_q <= 4'hF;
            pin_q <= 4'hF;
            cc_s1_q <= 4'h0;
            cc_s2_q <= 4'h0;
            cc_s3_q <= 4'h0;
            cc_q <= 4'h0;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_q <= dpp_agree(pin_q, pin_s2_q, pin_s3_q);
            cc_s1_q <= cc_raw;
            cc_s2_q <= cc_s1_q;
            cc_s3_q <= cc_s2_q;
            cc_q <= dpp_agree(cc_q, cc_s2_q, cc_s3_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= DPP_CTRL_RESET;
            status_q <= 8'h00;
            mask_q <= DPP_MASK_RESET;
            oc_lvl_q <= 4'h0;
            fault_lvl_q <= 4'h0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= pwdata & DPP_CTRL_WMASK;
            end
            if (wr_mask) begin
                mask_q <= pwdata[7:0];
            end
            status_q <= status_d;
            oc_lvl_q <= oc_now;
            fault_lvl_q <= fault_now;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (1'b1)
                hit_ctrl: prdata_q <= ctrl_q;
                hit_status: prdata_q <= {24'h000000, status_q};
                hit_mask: prdata_q <= {24'h000000, mask_q};
                hit_sense: prdata_q <= {22'h000000, bleed_q, fault_lvl_q, oc_lvl_q};
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_cc_gate;
        cc_en != 4'h0 |-> (cc_en & ~cc_gate) == 4'h0 && (cc_en & ~cc_req) == 4'h0;
    endproperty
    a_cc_gate: assert property (p_cc_gate) else $error("supply enable without request");

    property p_fault_sticky;
        $rose(fault_lvl_q[0]) |-> status_q[DPP_STAT_CC_LSB];
    endproperty
    a_fault_sticky: assert property (p_fault_sticky) else $error("fault not latched");

    property p_fault_hold;
        status_q[DPP_STAT_CC_LSB] && !(wr_status && pwdata[DPP_STAT_CC_LSB])
            |=> status_q[DPP_STAT_CC_LSB];
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault lost without clear");

    property p_bleed_end;
        bleed_q[0] && bleed_cnt_q[0] == 16'h0001 && !bleed_start[0] |=> !bleed_q[0];
    endproperty
    a_bleed_end: assert property (p_bleed_end) else $error("bleed overran interval");

    property p_bleed_start;
        bleed_start[0] && native_on[0] |=> bleed_q[0] && bleed_cnt_q[0] == 16'(BLEED_CYCLES);
    endproperty
    a_bleed_start: assert property (p_bleed_start) else $error("bleed did not start");

    property p_pin_mode;
        port_on[0] |-> power_ctl_pin.pull_up_en[0] && !power_ctl_pin.drive_oe[0];
    endproperty
    a_pin_mode: assert property (p_pin_mode) else $error("enabled pin not input");

    property p_pin_off;
        $fell(port_on[1]) |-> power_ctl_pin.drive_oe[1] && !power_ctl_pin.drive_out[1];
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("disabled pin not driven low");

    property p_oc_event;
        overcurrent_event[0] |-> port_on[0] && !pin_q[0] ##1 status_q[DPP_STAT_OC_LSB];
    endproperty
    a_oc_event: assert property (p_oc_event) else $error("bad overcurrent event");

    property p_no_split;
        !split |-> !port3_superspeed_split_power_en && ss_power_on[2] == port_on[2];
    endproperty
    a_no_split: assert property (p_no_split) else $error("split enable while unsplit");

    property p_split;
        split |-> ss_power_on[2] == port3_superspeed_split_power_en
            && hs_power_on[2] == port_on[2];
    endproperty
    a_split: assert property (p_split) else $error("split port 3 wrongly governed");

endmodule : dpp_port_power

// ==== verification/dpp_far_side.sv ====
// Model of the power switches, current monitors and cable supply at the pins.
// Assumes the testbench injects overcurrent and supply failures per port or line.
`timescale 1ns/1ps
module dpp_far_side import dpp_pkg::*; (
    input wire dpp_pctl_type pins,
    input wire logic [3:0] cc_en,
    input wire logic [3:0] oc_inj,
    input wire logic [3:0] cc_fail,
    output logic [3:0] sense,
    output logic [3:0] above
);
    ////////////////////////////////////////////////////////////////////////
    // monitor pulls low
    assign sense = (pins.drive_oe & pins.drive_out)
        | (~pins.drive_oe & pins.pull_up_en & ~oc_inj);
    assign above = cc_en & ~cc_fail;
endmodule : dpp_far_side

// ==== verification/tb_top.sv ====
// Self-checking bench of the downstream port power block.
// Assumes the far-side model and an APB master driven from this module.
`timescale 1ns/1ps
module tb_top import dpp_pkg::*;;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, c;
    logic pready, pslverr, bl1, bl2, split_en, irq, err;
    logic [3:0] off = 4'h0, oc_inj = 4'h0, cc_fail = 4'h0, sense, above, hs, ss, oce, sfe, p;
    wire [3:0] cc_en;
    wire [7:0] ev = {sfe, oce};
    dpp_pctl_type pins;
    int fail_count = 0, comparisons = 0, cycles = 0, seed = 11, n, m;
    dpp_port_power #(.BLEED_CYCLES(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .host_port_off(off),
        .port1_power_ctl_sense(sense[0]), .port2_power_ctl_sense(sense[1]),
        .port3_power_ctl_sense(sense[2]), .port4_power_ctl_sense(sense[3]), .power_ctl_pin(pins),
        .port1_cc1_above_3v0(above[0]), .port1_cc2_above_3v0(above[1]),
        .port2_cc1_above_3v0(above[2]), .port2_cc2_above_3v0(above[3]),
        .port1_cc1_cable_supply_en(cc_en[0]), .port1_cc2_cable_supply_en(cc_en[1]),
        .port2_cc1_cable_supply_en(cc_en[2]), .port2_cc2_cable_supply_en(cc_en[3]),
        .port1_vbus_bleed_en(bl1), .port2_vbus_bleed_en(bl2),
        .port3_superspeed_split_power_en(split_en), .hs_power_on(hs), .ss_power_on(ss),
        .overcurrent_event(oce), .supply_fault_event(sfe), .irq(irq));
    dpp_far_side far (.pins(pins), .cc_en(cc_en), .oc_inj(oc_inj), .cc_fail(cc_fail),
        .sense(sense), .above(above));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic logic [3:0] exp_cc(logic [31:0] v, logic [3:0] o);
        logic [1:0] q;
        q = v[1:0] & ~o[1:0] & ~v[17:16];
        return v[11:8] & {q[1], q[1], q[0], q[0]};
    endfunction : exp_cc
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        check("reset pins", 32'h0F0, 32'(pins));
        check("reset irq", 32'h0, 32'(irq));
        apb(0, DPP_CTRL_ADDR, 0);
        check("ctrl reset", DPP_CTRL_RESET, rd);
        apb(0, 8'h10, 0);
        check("unmapped err", 32'h1, 32'(err));
        apb(1, DPP_SENSE_ADDR, 32'hFFFF_FFFF);
        apb(0, DPP_SENSE_ADDR, 0);
        check("sense ro", 32'h0, rd);
        $display("test basic done");
        for (int i = 0; i < 16; i++) begin
            c = $random(seed) & ~32'h3000;
            off <= 4'($random(seed));
            apb(1, DPP_CTRL_ADDR, c);
            @(negedge pclk);
            p = c[3:0] & ~off;
            check("pins", 32'({p, ~p, 4'h0}), 32'(pins));
            check("cc en", 32'(exp_cc(c, off)), 32'(cc_en));
            check("hs on", 32'(p), 32'(hs));
            check("ss on", 32'({p[3], c[4] ? (p[2] & c[5]) : p[2], p[1:0]}), 32'(ss));
            check("split en", 32'(c[4] & p[2] & c[5]), 32'(split_en));
            apb(0, DPP_CTRL_ADDR, 0);
            check("ctrl rd", c & DPP_CTRL_WMASK, rd);
        end
        off <= 4'h0;
        $display("test random done");
        apb(1, DPP_CTRL_ADDR, 32'h0000_0F0F);
        repeat (8) @(posedge pclk);
        apb(1, DPP_STATUS_ADDR, 32'hFF);
        for (int k = 0; k < 8; k++) begin
            apb(1, DPP_MASK_ADDR, (k == 3) ? 32'h0 : 32'hFF);
            if (k < 4) oc_inj[k] <= 1'b1;
            else cc_fail[k - 4] <= 1'b1;
            n = 0;
            do begin
                @(negedge pclk);
                n++;
            end while (ev[k] !== 1'b1 && n < 20);
            check("event", 32'h1 << k, 32'({sfe, oce}));
            @(negedge pclk);
            check("irq", 32'(k != 3), 32'(irq));
            apb(0, DPP_STATUS_ADDR, 0);
            check("status", 32'h1 << k, rd);
            oc_inj <= 4'h0;
            cc_fail <= 4'h0;
            repeat (6) @(posedge pclk);
            apb(1, DPP_STATUS_ADDR, 32'h1 << k);
            apb(0, DPP_STATUS_ADDR, 0);
            check("cleared", 32'h0, rd);
        end
        $display("test faults done");
        apb(1, DPP_CTRL_ADDR, 32'h0);
        oc_inj <= 4'hF;
        repeat (8) @(posedge pclk);
        apb(0, DPP_STATUS_ADDR, 0);
        check("off ignored", 32'h0, rd);
        oc_inj <= 4'h0;
        apb(1, DPP_CTRL_ADDR, 32'h0000_0003);
        apb(1, DPP_CTRL_ADDR, 32'h0000_1003);
        n = 0;
        repeat (30) begin
            @(negedge pclk);
            n += bl1;
        end
        check("bleed len", 32'd8, 32'(n));
        check("bleed two off", 32'h0, 32'(bl2));
        apb(1, DPP_CTRL_ADDR, 32'h0001_0003);
        apb(1, DPP_CTRL_ADDR, 32'h0001_3003);
        n = 0;
        m = 0;
        repeat (30) begin
            @(negedge pclk);
            n += bl1;
            m += bl2;
        end
        check("legacy bleed", 32'd0, 32'(n));
        check("bleed two len", 32'd8, 32'(m));
        $display("test bleed done");
        finish_test();
    end
endmodule : tb_top
